// File: hw/dsc_supervisor.sv
/*
 * Supervision of a stepper driver: thermal flags, undervoltage and
 * power-up reset, serial status interface and clock source select.
 * Assumes comparator, supply and serial inputs already synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - compare temperature at 100 and 150 C
// - warning flag set at warning level
// - shutdown level disables bridge, sets flag
// - TC slope boosts gate current one step
// - undervoltage resets logic, disables all transistors
// - undervoltage clears all configuration to zero
// - in reset, respond zeros, no pass-through
// - reset clears current scale, energy reads zero
// - power-up holds serial interface, clears registers
// - internal oscillator nominal 15 MHz by default
// - first clock high switches to external
// - no fallback to oscillator once switched
// - standstill after 2^20 cycles without step
// - short protection held without running clock
// - hardware disable input frees motor
// - zero off-time disables transistors too
// - slope codes min, min+TC, med+TC, max
module dsc_supervisor #(
	parameter int STILL_BITS = dsc_pkg::STILL_BITS,
	parameter int SPI_W = dsc_pkg::SPI_W
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic temp_warn_cmp,
	input wire logic temp_shut_cmp,
	input wire logic logic_uv,
	input wire logic motor_uv,
	input wire logic hw_disable_input,
	input wire logic step_pulse,
	input wire logic ext_clk_in,
	input wire logic spi_cs_b,
	input wire logic spi_sck,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic bridge_enable,
	output logic logic_reset,
	output logic thermal_warning_flag,
	output logic thermal_shutdown_flag,
	output logic standstill_flag,
	output logic [1:0] hs_gate_step,
	output logic osc_enable,
	output logic ext_clk_selected,
	output logic s2g_protect_en
);
	typedef enum {DSC_OSC, DSC_EXT} dsc_clk_e;

	dsc_clk_e clk_src, next_clk_src;
	logic [dsc_pkg::POR_CNT_W-1:0] por_cnt, next_por_cnt;
	logic [STILL_BITS:0] still_cnt, next_still_cnt;
	logic [SPI_W-1:0] sreg, next_sreg;
	logic [1:0] slope, next_slope;
	logic [dsc_pkg::OFF_W-1:0] off_time, next_off_time;
	logic [dsc_pkg::CS_W-1:0] cur_scale, next_cur_scale;
	logic s2g_en, next_s2g_en;
	logic sck_q, cs_q;
	logic sys_rst, sck_rise, cs_fall, cs_rise;
	logic [1:0] base_step;

	function automatic logic [1:0] slope_base(input logic [1:0] s);
		case (s)
			dsc_pkg::SLOPE_MIN: slope_base = dsc_pkg::GATE_MIN;
			dsc_pkg::SLOPE_MIN_TC: slope_base = dsc_pkg::GATE_MIN;
			dsc_pkg::SLOPE_MED_TC: slope_base = dsc_pkg::GATE_MED;
			default: slope_base = dsc_pkg::GATE_MAX;
		endcase
	endfunction : slope_base

	function automatic logic slope_tc(input logic [1:0] s);
		slope_tc = (s == dsc_pkg::SLOPE_MIN_TC) ||
			(s == dsc_pkg::SLOPE_MED_TC);
	endfunction : slope_tc

	always_comb begin
		// either supply low holds the logic
		sys_rst = logic_uv | motor_uv | (por_cnt != '0);
		sck_rise = spi_sck & ~sck_q;
		cs_fall = ~spi_cs_b & cs_q;
		cs_rise = spi_cs_b & ~cs_q;
		base_step = slope_base(slope);
		// power-up hold restarts on any undervoltage
		if (logic_uv | motor_uv) begin
			next_por_cnt = dsc_pkg::POR_CNT_W'(dsc_pkg::POR_CYCLES);
		end else if (por_cnt != '0) begin
			next_por_cnt = por_cnt - 1'b1;
		end else begin
			next_por_cnt = por_cnt;
		end
	end

	always_comb begin
		next_clk_src = clk_src;
		// first high level commits to external clock
		// no path back to the oscillator
		case (clk_src)
			DSC_OSC: begin
				if (ext_clk_in) begin
					next_clk_src = DSC_EXT;
				end
			end
			DSC_EXT: next_clk_src = DSC_EXT;
			default: next_clk_src = DSC_OSC;
		endcase
	end

	always_comb begin
		next_sreg = sreg;
		next_slope = slope;
		next_off_time = off_time;
		next_cur_scale = cur_scale;
		next_s2g_en = s2g_en;
		// shift register held at zero in reset
		if (sys_rst) begin
			next_sreg = '0;
			next_slope = '0;
			next_off_time = '0;
			next_cur_scale = '0;
			next_s2g_en = 1'b0;
		end else if (cs_fall) begin
			next_sreg = '0;
			next_sreg[dsc_pkg::RSP_LOAD_LSB +: dsc_pkg::CS_W] = cur_scale;
			next_sreg[dsc_pkg::RSP_SHUT_BIT] = thermal_shutdown_flag;
			next_sreg[dsc_pkg::RSP_WARN_BIT] = thermal_warning_flag;
			next_sreg[dsc_pkg::RSP_STILL_BIT] = standstill_flag;
		end else if (~spi_cs_b & sck_rise) begin
			next_sreg = {sreg[SPI_W-2:0], spi_sdi};
		end else if (cs_rise) begin
			next_slope = sreg[dsc_pkg::CFG_SLOPE_LSB +: 2];
			next_off_time = sreg[dsc_pkg::CFG_OFF_LSB +: dsc_pkg::OFF_W];
			next_cur_scale = sreg[dsc_pkg::CFG_CS_LSB +: dsc_pkg::CS_W];
			next_s2g_en = sreg[dsc_pkg::CFG_S2G_BIT];
		end
	end

	always_comb begin
		// count clocks since the last step
		if (step_pulse | sys_rst) begin
			next_still_cnt = '0;
		end else if (!still_cnt[STILL_BITS]) begin
			next_still_cnt = still_cnt + 1'b1;
		end else begin
			next_still_cnt = still_cnt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			clk_src <= DSC_OSC;
			por_cnt <= dsc_pkg::POR_CNT_W'(dsc_pkg::POR_CYCLES);
			still_cnt <= '0;
			sreg <= '0;
			slope <= '0;
			off_time <= '0;
			cur_scale <= '0;
			s2g_en <= 1'b0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			spi_sdo <= 1'b0;
			bridge_enable <= 1'b0;
			logic_reset <= 1'b1;
			thermal_warning_flag <= 1'b0;
			thermal_shutdown_flag <= 1'b0;
			standstill_flag <= 1'b0;
			hs_gate_step <= dsc_pkg::GATE_MIN;
			osc_enable <= 1'b1;
			ext_clk_selected <= 1'b0;
			s2g_protect_en <= 1'b0;
		end else begin
			clk_src <= next_clk_src;
			por_cnt <= next_por_cnt;
			still_cnt <= next_still_cnt;
			sreg <= next_sreg;
			slope <= next_slope;
			off_time <= next_off_time;
			cur_scale <= next_cur_scale;
			s2g_en <= next_s2g_en;
			sck_q <= spi_sck;
			cs_q <= spi_cs_b;
			// nothing leaves the serial output in reset
			spi_sdo <= ~sys_rst & next_sreg[SPI_W-1];
			bridge_enable <= ~sys_rst & ~temp_shut_cmp &
				~hw_disable_input & (next_off_time != '0);
			logic_reset <= sys_rst;
			thermal_warning_flag <= temp_warn_cmp;
			thermal_shutdown_flag <= temp_shut_cmp;
			standstill_flag <= next_still_cnt[STILL_BITS];
			// one extra step when compensated and warm
			hs_gate_step <= (slope_tc(slope) & temp_warn_cmp) ?
				base_step + 2'h1 : base_step;
			// oscillator runs until external clock seen
			osc_enable <= (next_clk_src == DSC_OSC);
			ext_clk_selected <= (next_clk_src == DSC_EXT);
			// enable held statically, needs no clock edges
			s2g_protect_en <= next_s2g_en;
		end
	end

	default clocking dsc_cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	uv_bridge_off_a: assert property (
		(logic_uv | motor_uv) |=> !bridge_enable && logic_reset)
		else $error("bridge enabled during undervoltage");
	uv_cfg_clear_a: assert property (
		(logic_uv | motor_uv) |=> slope == '0 && off_time == '0)
		else $error("configuration not cleared");
	rst_sdo_zero_a: assert property (
		logic_reset |-> !spi_sdo)
		else $error("serial output active in reset");
	scale_clear_a: assert property (
		$rose(logic_reset) |-> cur_scale == '0)
		else $error("current scale survived reset");
	por_hold_a: assert property (
		$fell(motor_uv) && !logic_uv |=> logic_reset [*8])
		else $error("power-up hold too short");
	warn_flag_a: assert property (
		temp_warn_cmp |=> thermal_warning_flag)
		else $error("warning flag missed");
	shut_off_a: assert property (
		temp_shut_cmp |=> thermal_shutdown_flag && !bridge_enable)
		else $error("bridge on above shutdown level");
	gate_boost_a: assert property (
		slope == dsc_pkg::SLOPE_MED_TC && temp_warn_cmp && $stable(slope)
		|=> hs_gate_step == dsc_pkg::GATE_MAX)
		else $error("gate current not boosted");
	ext_sticky_a: assert property (
		ext_clk_selected |=> ext_clk_selected && !osc_enable)
		else $error("fell back to oscillator");
	ext_switch_a: assert property (
		ext_clk_in |=> ext_clk_selected)
		else $error("external clock not taken");
	dis_pin_a: assert property (
		hw_disable_input |=> !bridge_enable)
		else $error("bridge on with disable input high");
	off_zero_a: assert property (
		off_time == '0 && !cs_rise |=> !bridge_enable)
		else $error("bridge on with zero off-time");
	still_step_a: assert property (
		step_pulse |=> !standstill_flag)
		else $error("standstill despite step");

	cov_uv_c: cover property ($rose(logic_reset) ##[1:200] !logic_reset);
	cov_ext_c: cover property ($rose(ext_clk_selected));
	cov_shut_c: cover property ($rose(thermal_shutdown_flag));
	cov_cfg_c: cover property (cs_rise && !sys_rst);
endmodule : dsc_supervisor

`default_nettype wire

// File: hw/dsc_pkg.sv
/*
 * Constants for the driver supervision and clock select block.
 * Assumes a single 100 MHz system clock and synchronous inputs.
 */
package dsc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_FREQ_HZ = 15000000;
	localparam int TEMP_WARN_C = 100;
	localparam int TEMP_SHUT_C = 150;
	localparam int POR_HOLD_NS = 1000;
	localparam int POR_CYCLES = (POR_HOLD_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int POR_CNT_W = 8;
	localparam int STILL_BITS = 20;
	localparam int SPI_W = 20;
	// configuration word fields, captured at chip select release
	localparam int CFG_SLOPE_LSB = 18;
	localparam int CFG_OFF_LSB = 14;
	localparam int CFG_S2G_BIT = 13;
	localparam int CFG_CS_LSB = 0;
	localparam int OFF_W = 4;
	localparam int CS_W = 5;
	// response word fields, loaded at chip select assertion
	localparam int RSP_LOAD_LSB = 15;
	localparam int RSP_SHUT_BIT = 2;
	localparam int RSP_WARN_BIT = 1;
	localparam int RSP_STILL_BIT = 0;
	localparam logic [1:0] SLOPE_MIN = 2'h0;
	localparam logic [1:0] SLOPE_MIN_TC = 2'h1;
	localparam logic [1:0] SLOPE_MED_TC = 2'h2;
	localparam logic [1:0] SLOPE_MAX = 2'h3;
	localparam logic [1:0] GATE_MIN = 2'h0;
	localparam logic [1:0] GATE_MED = 2'h1;
	localparam logic [1:0] GATE_MAX = 2'h2;
	localparam logic [1:0] GATE_BOOST = 2'h3;
endpackage : dsc_pkg

// File: verification/dsc_host_model.sv
/* Host model: serial master, external clock and disable pin.
   Assumes the device samples every pin on sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
	input wire logic sys_clk,
	input wire logic spi_sdo,
	output logic spi_cs_b,
	output logic spi_sck,
	output logic spi_sdi,
	output logic ext_clk_in,
	output logic hw_disable_input
);
	initial begin
		{spi_cs_b, spi_sck, spi_sdi} = 3'h4;
		{ext_clk_in, hw_disable_input} = 2'h0;
	end
	// two words in one frame show whether data passes straight through
	task automatic xfer(input logic [19:0] tx, input int words,
		output logic [19:0] rx);
		@(posedge sys_clk);
		spi_cs_b <= 1'h0;
		repeat (3) @(posedge sys_clk);
		repeat (words) begin
			for (int i = 19; i >= 0; i--) begin
				spi_sdi <= tx[i];
				spi_sck <= 1'h0;
				@(negedge sys_clk) rx[i] = spi_sdo;
				repeat (2) @(posedge sys_clk);
				spi_sck <= 1'h1;
				repeat (2) @(posedge sys_clk);
			end
		end
		spi_sck <= 1'h0;
		repeat (2) @(posedge sys_clk);
		spi_cs_b <= 1'h1;
		// data line has no pull: idle shows the inverse of the last bit
		spi_sdi <= ~tx[0];
		repeat (3) @(posedge sys_clk);
	endtask : xfer
	task automatic set_dis(input logic v);
		@(posedge sys_clk);
		hw_disable_input <= v;
	endtask : set_dis
	// stage off first, 12.5 MHz whole periods, stops low
	task automatic run_clk(input int n);
		@(posedge sys_clk);
		hw_disable_input <= 1'h1;
		repeat (2 * n) begin
			@(posedge sys_clk);
			ext_clk_in <= ~ext_clk_in;
			repeat (3) @(posedge sys_clk);
		end
	endtask : run_clk
endmodule : dsc_host_model
`default_nettype wire

// File: verification/testbench.sv
/* Self-checking bench for dsc_supervisor driven by dsc_host_model.
   Assumes a 100 MHz sys_clk and a short standstill count. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk, rst_b, temp_warn_cmp, temp_shut_cmp;
	logic logic_uv, motor_uv, step_pulse;
	wire logic spi_cs_b, spi_sck, spi_sdi, spi_sdo, ext_clk_in;
	wire logic hw_disable_input, bridge_enable, logic_reset;
	wire logic thermal_warning_flag, thermal_shutdown_flag;
	wire logic standstill_flag, osc_enable, ext_clk_selected;
	wire logic s2g_protect_en;
	wire logic [1:0] hs_gate_step;
	logic [19:0] rx;
	int miscompares = 0;
	int compares = 0;
	dsc_supervisor #(.STILL_BITS(6)) dsc_supervisor_inst (.sys_clk,
		.rst_b, .temp_warn_cmp, .temp_shut_cmp, .logic_uv, .motor_uv,
		.hw_disable_input, .step_pulse, .ext_clk_in, .spi_cs_b,
		.spi_sck, .spi_sdi, .spi_sdo, .bridge_enable, .logic_reset,
		.thermal_warning_flag, .thermal_shutdown_flag, .standstill_flag,
		.hs_gate_step, .osc_enable, .ext_clk_selected, .s2g_protect_en);
	dsc_host_model dsc_host_model_inst (.sys_clk, .spi_sdo, .spi_cs_b,
		.spi_sck, .spi_sdi, .ext_clk_in, .hw_disable_input);
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic tally_and_finish;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_ready;
		for (int n = 0; logic_reset !== 1'h0; n++) begin
			if (n > 300) begin
				miscompares++;
				tally_and_finish();
			end
			@(negedge sys_clk);
		end
	endtask : wait_ready
	task automatic cfg(input logic [1:0] sl, input logic [3:0] off);
		dsc_host_model_inst.xfer({sl, off, 1'h1, 8'h00, 5'h15}, 1, rx);
	endtask : cfg
	task automatic t_por;
		dsc_host_model_inst.xfer(20'hFFFFF, 1, rx);
		chk(rx, 20'h0);
		chk(bridge_enable, 1'h0);
		chk(osc_enable, 1'h1);
		wait_ready();
		cfg(2'h1, 4'h5);
		chk(rx[19:15], 5'h0);
		chk(s2g_protect_en, 1'h1);
		$display("power-up test done");
	endtask : t_por
	task automatic t_slope;
		for (int c = 0; c < 4; c++) begin
			cfg(2'(c), 4'h5);
			temp_warn_cmp <= 1'h1;
			cfg(2'(c), 4'h5);
			chk(rx[19:15], 5'h15);
			chk(rx[1], 1'h1);
			chk(thermal_warning_flag, 1'h1);
			chk(hs_gate_step, {c == 3, c == 2} + (c == 1 || c == 2));
			tick(1);
			temp_warn_cmp <= 1'h0;
			tick(3);
			chk(hs_gate_step, {c == 3, c == 2});
		end
		$display("slope test done");
	endtask : t_slope
	task automatic t_hot;
		tick(1);
		temp_shut_cmp <= 1'h1;
		cfg(2'h0, 4'h5);
		chk(rx[2], 1'h1);
		chk({thermal_shutdown_flag, bridge_enable}, 2'h2);
		tick(1);
		temp_shut_cmp <= 1'h0;
		tick(3);
		chk(bridge_enable, 1'h1);
		dsc_host_model_inst.set_dis(1'h1);
		tick(3);
		chk(bridge_enable, 1'h0);
		dsc_host_model_inst.set_dis(1'h0);
		cfg(2'h0, 4'h0);
		chk(bridge_enable, 1'h0);
		cfg(2'h0, 4'h5);
		$display("thermal test done");
	endtask : t_hot
	task automatic t_still;
		tick(1);
		step_pulse <= 1'h1;
		tick(1);
		step_pulse <= 1'h0;
		tick(60);
		chk(standstill_flag, 1'h0);
		tick(8);
		chk(standstill_flag, 1'h1);
		$display("standstill test done");
	endtask : t_still
	task automatic t_uv;
		for (int i = 0; i < 2; i++) begin
			tick(1);
			{logic_uv, motor_uv} <= i ? 2'h1 : 2'h2;
			tick(3);
			chk({logic_reset, bridge_enable}, 2'h2);
			dsc_host_model_inst.xfer(20'hA5A5A, 2, rx);
			chk(rx, 20'h0);
			{logic_uv, motor_uv} <= 2'h0;
			wait_ready();
			chk(s2g_protect_en, 1'h0);
			cfg(2'h0, 4'h5);
			chk(rx[19:15], 5'h0);
		end
		$display("undervoltage test done");
	endtask : t_uv
	task automatic t_clk;
		dsc_host_model_inst.run_clk(3);
		chk({ext_clk_selected, osc_enable}, 2'h2);
		tick(20);
		chk({ext_clk_selected, osc_enable}, 2'h2);
		$display("clock select test done");
	endtask : t_clk
	initial begin
		{rst_b, temp_warn_cmp, temp_shut_cmp} = 3'h0;
		{logic_uv, motor_uv, step_pulse} = 3'h0;
		tick(12);
		rst_b <= 1'h1;
		t_por();
		t_slope();
		t_hot();
		t_still();
		t_uv();
		t_clk();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
